/* File: core/spi_bus_monitor_trigger.sv */
`timescale 1ns/1ns
`default_nettype none
module spi_bus_monitor_trigger (
   input  wire logic                                ref_clk,
   input  wire logic                                rstn,
   input  wire logic                                bus_clk,
   input  wire logic                                cs_pin,
   input  wire logic                                mosi_pin,
   input  wire logic                                miso_pin,
   input  wire logic                                cs_mode,
   input  wire logic                                slope_falling,
   input  wire logic [spi_mon_pkg::WLEN_W-1:0]      word_len,
   input  wire logic                                lsb_first,
   input  wire logic [spi_mon_pkg::IDLE_W-1:0]      idle_cycles,
   input  wire logic                                miso_en,
   input  wire logic                                odd_instance,
   input  wire logic                                pol_wr,
   input  wire logic                                pol_cs_low_in,
   input  wire logic                                pol_mosi_low_in,
   input  wire logic                                pol_miso_low_in,
   input  wire logic [1:0]                          trig_mode,
   input  wire logic                                trig_src_miso,
   input  wire logic [spi_mon_pkg::CNT_W-1:0]       bit_offset,
   input  wire logic [spi_mon_pkg::WLEN_W-1:0]      match_length,
   input  wire logic [31:0]                         pat_data,
   input  wire logic [31:0]                         pat_care,
   output logic                                     word_valid,
   output logic      [31:0]                         mosi_word,
   output logic      [31:0]                         miso_word,
   output logic                                     frame_start,
   output logic                                     frame_end,
   output logic      [spi_mon_pkg::CNT_W-1:0]       frame_words,
   output logic                                     in_frame,
   output logic                                     trig,
   output logic      [spi_mon_pkg::CNT_W-1:0]       trig_bit,
   output logic                                     partner_taken
);
   typedef struct packed {
      spi_mon_pkg::mon_state_t         state;
      logic                            cs_s1;
      logic                            cs_s2;
      logic                            pol_cs_low;
      logic                            pol_mosi_low;
      logic                            pol_miso_low;
      logic                            slope_q;
      logic [spi_mon_pkg::RING_AW-1:0] rd_ptr;
      logic [spi_mon_pkg::IDLE_W-1:0]  idle_cnt;
      logic [spi_mon_pkg::CNT_W-1:0]   bit_cnt;
      logic [spi_mon_pkg::CNT_W-1:0]   word_cnt;
      logic [spi_mon_pkg::WLEN_W-1:0]  word_bits;
      logic [31:0]                     acc_mosi;
      logic [31:0]                     acc_miso;
      logic [31:0]                     hist;
      logic                            word_valid;
      logic [31:0]                     mosi_word;
      logic [31:0]                     miso_word;
      logic                            frame_start;
      logic                            frame_end;
      logic [spi_mon_pkg::CNT_W-1:0]   frame_words;
      logic                            trig;
      logic [spi_mon_pkg::CNT_W-1:0]   trig_bit;
      logic                            partner_taken;
   } mon_t;

   mon_t s_reg, s_next;
   logic [spi_mon_pkg::RING_AW-1:0] wp_rise, wp_fall, wp_sel;
   logic [1:0]                      rb_rise, rb_fall, rb_sel;
   logic                            cs_act, have_bit, idle_done, miso_ok;
   logic                            b_mosi, b_miso, b_src, fresh, take, close;
   logic [spi_mon_pkg::WLEN_W-1:0]  wl, ml, wb_new;
   logic [spi_mon_pkg::CNT_W-1:0]   bc_new, wc_base, words_tot;
   logic [31:0]                     am, ai, hist_new, len_mask;

   // One capture ring per bus edge; the slope choice picks which one is read
   bit_ring u_ring_rise (
      .link_clk   (bus_clk),
      .rstn       (rstn),
      .bits_in    ({miso_pin, mosi_pin}),
      .ref_clk    (ref_clk),
      .rd_idx     (s_reg.rd_ptr),
      .wr_ptr_ref (wp_rise),
      .rd_bits    (rb_rise)
   );
   bit_ring u_ring_fall (
      .link_clk   (~bus_clk),
      .rstn       (rstn),
      .bits_in    ({miso_pin, mosi_pin}),
      .ref_clk    (ref_clk),
      .rd_idx     (s_reg.rd_ptr),
      .wr_ptr_ref (wp_fall),
      .rd_bits    (rb_fall)
   );

   // Decoder next state
   always_comb begin
      s_next = s_reg;
      s_next.word_valid  = 1'h0;
      s_next.frame_start = 1'h0;
      s_next.frame_end   = 1'h0;
      s_next.trig        = 1'h0;
      s_next.cs_s1 = cs_pin;
      s_next.cs_s2 = s_reg.cs_s1;
      if (pol_wr) begin
         s_next.pol_cs_low   = pol_cs_low_in;
         s_next.pol_mosi_low = pol_mosi_low_in;
         s_next.pol_miso_low = pol_miso_low_in;
      end
      // Odd instance borrows the even partner's input for master-in
      miso_ok = miso_en && odd_instance;
      s_next.partner_taken = miso_ok;
      cs_act = s_reg.cs_s2 ^ s_reg.pol_cs_low;
      wp_sel = slope_falling ? wp_fall : wp_rise;
      rb_sel = slope_falling ? rb_fall : rb_rise;
      s_next.slope_q = slope_falling;
      have_bit = (s_reg.slope_q == slope_falling) && (wp_sel != s_reg.rd_ptr);
      // Slope change drops what the old ring held rather than mixing edges
      if (s_reg.slope_q != slope_falling) begin
         s_next.rd_ptr = wp_sel;
      end else if (have_bit) begin
         s_next.rd_ptr = s_reg.rd_ptr + 1'h1;
      end
      b_mosi = rb_sel[0] ^ s_reg.pol_mosi_low;
      b_miso = miso_ok & (rb_sel[1] ^ s_reg.pol_miso_low);
      b_src  = (trig_src_miso && miso_ok) ? b_miso : b_mosi;
      // Idle timer restarts on every sampled edge
      idle_done = (s_reg.idle_cnt == idle_cycles) && !have_bit;
      if (have_bit) begin
         s_next.idle_cnt = '0;
      end else if (!idle_done) begin
         s_next.idle_cnt = s_reg.idle_cnt + 1'h1;
      end
      // Lengths of 0 or above the maximum read as the maximum
      wl = (word_len == '0 || word_len > 6'h20) ? 6'h20 : word_len;
      ml = (match_length == '0 || match_length > 6'h20) ? 6'h20 : match_length;
      len_mask = 32'hFFFFFFFF >> (6'h20 - ml);
      fresh = 1'h0;
      take  = 1'h0;
      close = 1'h0;
      unique case (s_reg.state)
         spi_mon_pkg::ST_WAIT: begin
            if (cs_mode && cs_act) begin
               s_next.state = spi_mon_pkg::ST_FRAME;
               s_next.frame_start = 1'h1;
               fresh = 1'h1;
            end else if (!cs_mode && idle_done) begin
               s_next.state = spi_mon_pkg::ST_ARMED;
            end
         end
         spi_mon_pkg::ST_ARMED: begin
            if (cs_mode) begin
               s_next.state = spi_mon_pkg::ST_WAIT;
            end else if (have_bit) begin
               s_next.state = spi_mon_pkg::ST_FRAME;
               s_next.frame_start = 1'h1;
               fresh = 1'h1;
               take  = 1'h1;
            end
         end
         spi_mon_pkg::ST_FRAME: begin
            close = cs_mode ? !cs_act : idle_done;
            take  = have_bit && !close;
         end
      endcase
      if (s_next.frame_start && trig_mode == spi_mon_pkg::TRIG_START) begin
         s_next.trig     = 1'h1;
         s_next.trig_bit = '0;
      end
      // Bit handling; a fresh frame starts from cleared counters
      bc_new   = (fresh ? '0 : s_reg.bit_cnt) + 1'h1;
      wb_new   = (fresh ? '0 : s_reg.word_bits) + 1'h1;
      wc_base  = fresh ? '0 : s_reg.word_cnt;
      am       = fresh ? '0 : s_reg.acc_mosi;
      ai       = fresh ? '0 : s_reg.acc_miso;
      hist_new = {s_reg.hist[30:0], b_src};
      if (fresh) begin
         s_next.bit_cnt   = '0;
         s_next.word_cnt  = '0;
         s_next.word_bits = '0;
         s_next.acc_mosi  = '0;
         s_next.acc_miso  = '0;
      end
      if (take) begin
         s_next.bit_cnt = bc_new;
         s_next.hist    = hist_new;
         if (lsb_first) begin
            am[s_next.word_bits[4:0]] = b_mosi;
            ai[s_next.word_bits[4:0]] = b_miso;
         end else begin
            am = {am[30:0], b_mosi};
            ai = {ai[30:0], b_miso};
         end
         if (wb_new == wl) begin
            s_next.word_valid = 1'h1;
            s_next.mosi_word  = am;
            s_next.miso_word  = ai;
            s_next.word_cnt   = wc_base + 1'h1;
            s_next.word_bits  = '0;
            s_next.acc_mosi   = '0;
            s_next.acc_miso   = '0;
         end else begin
            s_next.word_bits = wb_new;
            s_next.acc_mosi  = am;
            s_next.acc_miso  = ai;
         end
         if (trig_mode == spi_mon_pkg::TRIG_BIT && bc_new == bit_offset + 1'h1) begin
            s_next.trig     = 1'h1;
            s_next.trig_bit = bc_new;
         end
         if (trig_mode == spi_mon_pkg::TRIG_PATTERN
             && bc_new == bit_offset + spi_mon_pkg::CNT_W'(ml)
             && ((hist_new ^ pat_data) & pat_care & len_mask) == 32'h0) begin
            s_next.trig     = 1'h1;
            s_next.trig_bit = bit_offset + 1'h1;
         end
      end
      // Frame close flushes a partial word; empty frames are not reported
      words_tot = s_reg.word_cnt + ((s_reg.word_bits != '0) ? 1'h1 : 1'h0);
      if (close) begin
         s_next.state = cs_mode ? spi_mon_pkg::ST_WAIT : spi_mon_pkg::ST_ARMED;
         if (s_reg.word_bits != '0) begin
            s_next.word_valid = 1'h1;
            s_next.mosi_word  = s_reg.acc_mosi;
            s_next.miso_word  = s_reg.acc_miso;
         end
         s_next.word_bits = '0;
         s_next.acc_mosi  = '0;
         s_next.acc_miso  = '0;
         if (words_tot != '0) begin
            s_next.frame_end   = 1'h1;
            s_next.frame_words = words_tot;
            if (trig_mode == spi_mon_pkg::TRIG_END) begin
               s_next.trig     = 1'h1;
               s_next.trig_bit = s_reg.bit_cnt;
            end
         end
      end
   end

   // Synchronous reset back to waiting for a frame
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         s_reg <= '0;
         s_reg.state <= spi_mon_pkg::ST_WAIT;
         // Sync stages start at the inactive select level, so no false frame follows reset
         s_reg.cs_s1 <= spi_mon_pkg::POL_CS_LOW_RST;
         s_reg.cs_s2 <= spi_mon_pkg::POL_CS_LOW_RST;
         s_reg.pol_cs_low <= spi_mon_pkg::POL_CS_LOW_RST;
         s_reg.pol_mosi_low <= spi_mon_pkg::POL_DATA_LOW_RST;
         s_reg.pol_miso_low <= spi_mon_pkg::POL_DATA_LOW_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign word_valid    = s_reg.word_valid;
   assign mosi_word     = s_reg.mosi_word;
   assign miso_word     = s_reg.miso_word;
   assign frame_start   = s_reg.frame_start;
   assign frame_end     = s_reg.frame_end;
   assign frame_words   = s_reg.frame_words;
   assign in_frame      = s_reg.state[2]; // One-hot frame bit, straight from its flop
   assign trig          = s_reg.trig;
   assign trig_bit      = s_reg.trig_bit;
   assign partner_taken = s_reg.partner_taken;

   a_start_trigger: assert property (@(posedge ref_clk) disable iff (!rstn)
      frame_start && $past(trig_mode) == spi_mon_pkg::TRIG_START |-> trig)
      else $error("frame start did not trigger");
   a_frame_words_nonzero: assert property (@(posedge ref_clk) disable iff (!rstn)
      frame_end |-> frame_words != '0)
      else $error("frame reported with zero words");
   a_pol_reset_default: assert property (@(posedge ref_clk)
      !rstn |=> s_reg.pol_cs_low && !s_reg.pol_mosi_low && !s_reg.pol_miso_low)
      else $error("polarity reset defaults wrong");
   a_frame_end_close: assert property (@(posedge ref_clk) disable iff (!rstn)
      frame_end |-> !in_frame && $past(in_frame))
      else $error("frame end outside a frame");
   a_cs_frame_open: assert property (@(posedge ref_clk) disable iff (!rstn)
      frame_start && $past(cs_mode) |-> $past(cs_act) && in_frame)
      else $error("select frame opened while select inactive");
   a_idle_frame_open: assert property (@(posedge ref_clk) disable iff (!rstn)
      frame_start && !$past(cs_mode) |-> $past(s_reg.state) == spi_mon_pkg::ST_ARMED)
      else $error("frame opened before idle time elapsed");
   a_word_restart: assert property (@(posedge ref_clk) disable iff (!rstn)
      word_valid |-> s_reg.word_bits == '0 ##1 s_reg.word_bits <= 6'h1)
      else $error("word accumulation not restarted");
   a_bit_trigger: assert property (@(posedge ref_clk) disable iff (!rstn)
      trig && $past(trig_mode) == spi_mon_pkg::TRIG_BIT |-> trig_bit == $past(bit_offset) + 1'h1)
      else $error("bit trigger at wrong bit");
   a_end_trigger: assert property (@(posedge ref_clk) disable iff (!rstn)
      frame_end && $past(trig_mode) == spi_mon_pkg::TRIG_END
         |-> trig && trig_bit == $past(s_reg.bit_cnt))
      else $error("frame end trigger missing or at wrong bit");
   a_pattern_trigger: assert property (@(posedge ref_clk) disable iff (!rstn)
      trig && $past(trig_mode) == spi_mon_pkg::TRIG_PATTERN
         |-> trig_bit == $past(bit_offset) + 1'h1)
      else $error("pattern trigger not at first pattern bit");
   a_idle_close: assert property (@(posedge ref_clk) disable iff (!rstn)
      frame_end && !$past(cs_mode) |-> $past(s_reg.idle_cnt) == $past(idle_cycles))
      else $error("select-less frame closed before idle time");
   a_reset_clear: assert property (@(posedge ref_clk)
      !rstn |=> s_reg.bit_cnt == '0 && s_reg.idle_cnt == '0 && s_reg.word_bits == '0
         && s_reg.state == spi_mon_pkg::ST_WAIT)
      else $error("reset left decoder state");
endmodule
`default_nettype wire

/* File: core/spi_mon_pkg.sv */
// Functional notes
// - Sample on chosen clock edge; edge starts bit
// - Each line has selectable polarity
// - Reset polarity: select active-low, data active-high
// - Word length programmable up to 32 bits
// - Bit order places first bit MSB or LSB
// - Consecutive bits assemble into configured-length words
// - A frame never reports zero words
// - Programmable idle time in select-less mode
// - Select-less frame starts only after full idle
// - Gaps shorter than idle keep same frame
// - Master-out mandatory, master-in optional
// - Odd instance master-in claims paired even instance
// - Selector picks master-out or master-in for trigger
// - Trigger on start, end, bit, or pattern
// - Both data directions captured together per bit
// - Select active opens frame, inactive closes it
// - Select-less frame ends after idle without clock
// - Bits count from 1; offset skips, then trigger
// - Masked pattern match triggers at pattern's first bit
`default_nettype none
package spi_mon_pkg;
   localparam int WORD_MAX = 32;
   localparam int WLEN_W   = 6;
   localparam int RING_AW  = 3;
   localparam int IDLE_W   = 20;
   localparam int CNT_W    = 16;
   // Polarity flags: 1 means a low level reads as logic one / active
   localparam logic POL_CS_LOW_RST   = 1'h1;
   localparam logic POL_DATA_LOW_RST = 1'h0;
   localparam logic [1:0] TRIG_START   = 2'h0;
   localparam logic [1:0] TRIG_END     = 2'h1;
   localparam logic [1:0] TRIG_BIT     = 2'h2;
   localparam logic [1:0] TRIG_PATTERN = 2'h3;
   typedef enum logic [2:0] {
      ST_WAIT  = 3'h1,
      ST_ARMED = 3'h2,
      ST_FRAME = 3'h4
   } mon_state_t;
endpackage
`default_nettype wire

/* File: core/bit_ring.sv */
`timescale 1ns/1ns
`default_nettype none
module bit_ring (
   input  wire logic                                link_clk,
   input  wire logic                                rstn,
   input  wire logic [1:0]                          bits_in,
   input  wire logic                                ref_clk,
   input  wire logic [spi_mon_pkg::RING_AW-1:0]     rd_idx,
   output logic      [spi_mon_pkg::RING_AW-1:0]     wr_ptr_ref,
   output logic      [1:0]                          rd_bits
);
   typedef struct packed {
      logic                            rst_s1;
      logic                            rst_s2;
      logic [spi_mon_pkg::RING_AW-1:0] wbin;
      logic [spi_mon_pkg::RING_AW-1:0] wgray;
   } link_t;
   typedef struct packed {
      logic [spi_mon_pkg::RING_AW-1:0] g_s1;
      logic [spi_mon_pkg::RING_AW-1:0] g_s2;
   } sync_t;

   logic [1:0] mem [0:(1<<spi_mon_pkg::RING_AW)-1];
   link_t l_reg, l_next;
   sync_t y_reg, y_next;
   logic [spi_mon_pkg::RING_AW-1:0] inc;

   // Link side: bus edge writes the bit pair and publishes the gray pointer on that same edge
   always_comb begin
      inc = l_reg.wbin + 1'h1;
      l_next = l_reg;
      l_next.rst_s1 = rstn;
      l_next.rst_s2 = l_reg.rst_s1;
      if (!l_reg.rst_s2) begin
         l_next.wbin  = '0;
         l_next.wgray = '0;
      end else begin
         l_next.wbin  = inc;
         l_next.wgray = inc ^ (inc >> 1);
      end
   end

   always_ff @(posedge link_clk) begin
      l_reg <= l_next;
      mem[l_reg.wbin] <= bits_in;
   end

   // Two-stage pointer sync; entry is stable long before its pointer arrives
   always_comb begin
      y_next = y_reg;
      y_next.g_s1 = l_reg.wgray;
      y_next.g_s2 = y_reg.g_s1;
   end

   always_ff @(posedge ref_clk) begin
      y_reg <= y_next;
   end

   // Gray to binary, one generate block per bit
   genvar i;
   for (i = 0; i < spi_mon_pkg::RING_AW; i++) begin : g_bin
      assign wr_ptr_ref[i] = ^(y_reg.g_s2 >> i);
   end
   assign rd_bits = mem[rd_idx];
endmodule
`default_nettype wire

/* File: sim/spi_bus_model.sv */
`timescale 1ns/1ns
`default_nettype none
module spi_bus_model (
   input  wire logic rstn,
   output var  logic bus_clk,
   output var  logic cs_pin,
   output var  logic mosi_pin,
   output var  logic miso_pin
);
   bit busy = 1'b0;
   int tail = 0;

   // Clock runs under reset and a few edges past release; the rings leave reset
   // only on their own edges, so without the tail the first frame loses bits
   initial begin
      bus_clk = 1'b0;
      cs_pin = 1'b1;
      mosi_pin = 1'b0;
      miso_pin = 1'b0;
      forever begin
         #32;
         tail = !rstn ? 8 : (tail > 0) ? tail - 1 : 0;
         if (!busy) begin
            bus_clk = (tail > 0) ? ~bus_clk : 1'b0;
         end
      end
   end

   // Inactive select level, changed only while no frame runs
   task automatic set_cs(input logic lvl);
      cs_pin = lvl;
   endtask

   // Both lines change together, stable across both clock edges of a bit
   task automatic frame(input bit csm, input logic act, input int n,
                        input logic [63:0] mo, input logic [63:0] mi, input int gap);
      busy = 1'b1;
      if (csm) begin
         cs_pin = act;
         #400;
      end
      for (int i = 0; i < n; i++) begin
         mosi_pin = mo[i];
         miso_pin = mi[i];
         #16 bus_clk = 1'b1;
         #32 bus_clk = 1'b0;
         #16;
         if (i == gap) begin
            #320;
         end
      end
      #400;
      cs_pin = csm ? ~act : cs_pin;
      // Released lines are not held, so show the inverse of the last bit
      mosi_pin = ~mosi_pin;
      miso_pin = ~miso_pin;
      busy = 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic                           ref_clk, rstn, bus_clk, cs_pin, mosi_pin, miso_pin;
   logic                           cs_mode, slope_falling, lsb_first, miso_en, odd_instance;
   logic                           pol_wr, pol_cs_low_in, pol_mosi_low_in, pol_miso_low_in;
   logic                           trig_src_miso, word_valid, frame_start, frame_end;
   logic                           in_frame, trig, partner_taken, saw_in, pcs, pmo, pmi;
   logic [spi_mon_pkg::WLEN_W-1:0] word_len, match_length;
   logic [spi_mon_pkg::IDLE_W-1:0] idle_cycles;
   logic [1:0]                     trig_mode;
   logic [spi_mon_pkg::CNT_W-1:0]  bit_offset, frame_words, trig_bit;
   logic [31:0]                    pat_data, pat_care, mosi_word, miso_word, seen_fw, seen_tb;
   logic [31:0]                    q_mo[$], q_mi[$];
   logic [31:0]                    seed = 32'h00000048;
   int                             n_errors = 0;
   int                             n_checks = 0;
   int                             n_fs, n_fe, n_tr;

   spi_bus_model bus (.rstn(rstn), .bus_clk(bus_clk), .cs_pin(cs_pin), .mosi_pin(mosi_pin),
                      .miso_pin(miso_pin));
   spi_bus_monitor_trigger uut (.ref_clk(ref_clk), .rstn(rstn), .bus_clk(bus_clk),
      .cs_pin(cs_pin), .mosi_pin(mosi_pin), .miso_pin(miso_pin), .cs_mode(cs_mode),
      .slope_falling(slope_falling), .word_len(word_len), .lsb_first(lsb_first),
      .idle_cycles(idle_cycles), .miso_en(miso_en), .odd_instance(odd_instance),
      .pol_wr(pol_wr), .pol_cs_low_in(pol_cs_low_in), .pol_mosi_low_in(pol_mosi_low_in),
      .pol_miso_low_in(pol_miso_low_in), .trig_mode(trig_mode), .trig_src_miso(trig_src_miso),
      .bit_offset(bit_offset), .match_length(match_length), .pat_data(pat_data),
      .pat_care(pat_care), .word_valid(word_valid), .mosi_word(mosi_word),
      .miso_word(miso_word), .frame_start(frame_start), .frame_end(frame_end),
      .frame_words(frame_words), .in_frame(in_frame), .trig(trig), .trig_bit(trig_bit),
      .partner_taken(partner_taken));

   // 25 MHz decoder clock
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // Collect one-cycle pulses; values read before this edge's updates land
   always @(posedge ref_clk) begin
      if (word_valid) begin
         q_mo.push_back(mosi_word);
         q_mi.push_back(miso_word);
      end
      if (frame_start) n_fs++;
      if (frame_end) begin
         n_fe++;
         seen_fw = 32'(frame_words);
      end
      if (trig) begin
         n_tr++;
         seen_tb = 32'(trig_bit);
      end
      if (in_frame) saw_in = 1'b1;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Inputs move a fixed 2 ns after the rising edge
   task automatic step(input int k);
      repeat (k) @(posedge ref_clk);
      #2;
   endtask

   function automatic logic [31:0] rnd();
      for (int i = 0; i < 32; i++) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   // Right-aligned word of m bits starting at bit s of the frame
   function automatic logic [31:0] exp_word(logic [63:0] d, int s, int m, logic lsb);
      logic [31:0] w;
      w = 32'h0;
      for (int j = 0; j < m; j++) w[lsb ? j : m - 1 - j] = d[s + j];
      return w;
   endfunction

   initial begin
      int n, w, nw, m, off, len, k;
      logic [63:0] mo, mi, src;
      logic [31:0] r, exp_tr, exp_bit;
      logic mu;
      {rstn, cs_mode, slope_falling, lsb_first, miso_en, odd_instance, pol_wr} = 7'h00;
      {pol_cs_low_in, pol_mosi_low_in, pol_miso_low_in, trig_src_miso} = 4'h0;
      {word_len, match_length, trig_mode, bit_offset} = 30'h0;
      {pat_data, pat_care} = 64'h0;
      idle_cycles = 20'h00014;
      {pcs, pmo, pmi} = 3'b100;
      step(12);
      rstn = 1'b1;
      step(1);
      check({word_valid, frame_start, frame_end, in_frame, trig, partner_taken}, 0);
      check({frame_words, trig_bit}, 0);
      // Random configurations; the first keeps reset polarities, two fix word-size corners
      for (int it = 0; it < 12; it++) begin
         r = rnd();
         cs_mode = 1'b0;
         {miso_en, odd_instance, trig_src_miso, lsb_first, slope_falling} = r[4:0];
         if (it == 4) {miso_en, odd_instance, trig_src_miso} = 3'b101;
         if (it == 11) {miso_en, odd_instance, trig_src_miso} = 3'b111;
         trig_mode = it[1:0];
         if (it > 0) begin
            {pcs, pmo, pmi} = r[7:5];
            {pol_cs_low_in, pol_mosi_low_in, pol_miso_low_in} = r[7:5];
            pol_wr = 1'b1;
            step(1);
            pol_wr = 1'b0;
         end
         bus.set_cs(pcs);
         w = (it == 0) ? 32 : (it == 1) ? 1 : 1 + int'(r[12:8]);
         n = (it == 0) ? 64 : 17 + int'(r[31:16] % 48);
         mo = {rnd(), rnd()};
         mi = {rnd(), rnd()};
         mu = miso_en & odd_instance;
         src = (trig_src_miso & mu) ? mi : mo;
         len = 1 + int'(rnd() % 16);
         off = (trig_mode == 2'h3) ? int'(rnd() % (n - len + 1)) : int'(rnd() % n);
         word_len = w[5:0];
         match_length = len[5:0];
         bit_offset = off[15:0];
         pat_data = rnd();
         pat_care = rnd() | 32'h1;
         for (int i = 0; i < len; i++) pat_data[len - 1 - i] = src[off + i];
         exp_tr = 1;
         // A cared bit turned round must suppress the pattern trigger
         if (it == 7) begin
            pat_data[0] = ~pat_data[0];
            exp_tr = 0;
         end
         exp_bit = (trig_mode == 2'h0) ? 0 : (trig_mode == 2'h1) ? n : off + 1;
         step(30);
         cs_mode = it[2];
         step(30);
         {n_fs, n_fe, n_tr} = '0;
         saw_in = 1'b0;
         q_mo.delete();
         q_mi.delete();
         bus.frame(cs_mode, ~pcs, n, mo ^ {64{pmo}}, mi ^ {64{pmi}}, n / 2);
         for (k = 0; k < 300 && n_fe == 0; k++) step(1);
         if (n_fe == 0) begin
            check(32'h0, 32'h1);
            break;
         end
         step(10);
         nw = (n + w - 1) / w;
         check(n_fs, 1);
         check(n_fe, 1);
         check(seen_fw, nw);
         check(q_mo.size(), nw);
         for (k = 0; k < nw; k++) begin
            m = (n - k * w < w) ? n - k * w : w;
            check(q_mo[k], exp_word(mo, k * w, m, lsb_first));
            check(q_mi[k], mu ? exp_word(mi, k * w, m, lsb_first) : 0);
         end
         check(n_tr, exp_tr);
         if (exp_tr == 1) check(seen_tb, exp_bit);
         check(partner_taken, mu);
         check({in_frame, saw_in}, 2'b01);
         $display("test %0d done", it);
      end
      complete_run();
   end
endmodule
`default_nettype wire
